// file: hdl/acbc_top.sv
// Channel selection and result buffer control of a converter sequencer.
// Assumes an APB master on CLK and a conversion-done pulse from the
// analog side, which is asynchronous and is synchronised here.
//
// Behaviour
// RULE_01: channel code picks one, two or four channels.
// RULE_02: twelve-bit mode reads channel code as zero.
// RULE_03: channel code sits in bits nine and eight.
// RULE_04: half status matters only in split mode.
// RULE_05: half status one while second half fills.
// RULE_06: event after every rate plus one operations.
// RULE_07: split mode alternates halves at each event.
// RULE_08: plain mode restarts buffer after each event.
// RULE_09: scan bit steps input; unused bits read zero.
`timescale 1ns/100ps
`default_nettype none
`include "acbc_map.svh"

module acbc_top #(
   parameter int BUF_DEPTH = 16,
   parameter int AW        = $clog2(BUF_DEPTH)
) (
   input  wire logic              CLK,
   input  wire logic              RESET_N,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [7:0]        PADDR,
   input  wire acbc_pkg::acbc_word_t PWDATA,
   output var acbc_pkg::acbc_word_t PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              CONV_DONE,
   output logic [1:0]             CHANNEL_COUNT,
   output logic                   SCAN_ENABLE,
   output logic [3:0]             CH0_POS_INPUT,
   output logic                   DMA_INC,
   output logic                   BUF_HALF,
   output logic [AW-1:0]          BUF_ADDR,
   output logic                   IRQ
);
   import acbc_pkg::*;

   if (BUF_DEPTH < 4 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad
      $error("acbc_top: BUF_DEPTH must be a power of two, 4 or more");
   end

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Next enabled scan input after idx; an empty list keeps idx.
   function automatic logic [3:0] next_scan(input logic [3:0] idx,
                                            input logic [15:0] list);
      logic [3:0] cand;
      logic       found;
      next_scan = idx;
      found     = 1'b0;
      for (int i = 1; i <= 16; i++) begin
         cand = idx + i[3:0];
         if (!found && list[cand]) begin
            next_scan = cand;
            found     = 1'b1;
         end
      end
   endfunction : next_scan

   // Effective channel code: forced to one channel in twelve-bit mode.
   function automatic logic [1:0] eff_chan(input logic [1:0] code,
                                           input logic twelve);
      eff_chan = twelve ? 2'h0 : code;
   endfunction : eff_chan

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [1:0]  chan_code;
   logic        scan_en;
   logic [3:0]  rate;
   logic        split;
   logic        twelve;
   logic [3:0]  fixed_in;
   logic [15:0] scan_list;
   logic [1:0]  status;
   logic [1:0]  mask;
   logic        half;
   logic [AW-1:0] addr;
   logic [3:0]  scan_idx;

   logic        wr_en;
   logic        rd_en;
   logic        setup;
   logic        hit;
   logic        ctrl_wr;
   logic        op_done;
   logic [15:0] ctrl_view;
   acbc_word_t  next_rdata;
   logic        next_err;

   // Write and read take effect in the access cycle with PREADY high.
   assign setup = PSEL && !PENABLE;
   assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
   assign rd_en = PSEL && PENABLE && PREADY && !PWRITE;
   assign ctrl_wr = wr_en && PADDR == `ACBC_OFF_CTRL;

   // ------------------------------------------------------------
   // Conversion-done synchroniser
   // ------------------------------------------------------------
   logic done_s1;
   logic done_s2;
   logic done_s3;

   // The pin is asynchronous; the edge is taken from the second stage.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
         done_s3 <= 1'b0;
      end else begin
         done_s1 <= CONV_DONE;
         done_s2 <= done_s1;
         done_s3 <= done_s2;
      end
   end

   assign op_done = done_s2 && !done_s3;

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   // Software fields; the half status bit is not writable.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         chan_code <= 2'(`ACBC_RST_CTRL >> `ACBC_F_CHAN_LO);
         scan_en   <= 1'(`ACBC_RST_CTRL >> `ACBC_F_SCAN);
         rate      <= 4'(`ACBC_RST_CTRL >> `ACBC_F_RATE_LO);
         split     <= 1'(`ACBC_RST_CTRL >> `ACBC_F_SPLIT);
      end else if (ctrl_wr) begin
         chan_code <= PWDATA[`ACBC_F_CHAN_HI:`ACBC_F_CHAN_LO]; // see RULE_03
         scan_en   <= PWDATA[`ACBC_F_SCAN];
         rate      <= PWDATA[`ACBC_F_RATE_HI:`ACBC_F_RATE_LO];
         split     <= PWDATA[`ACBC_F_SPLIT];
      end
   end

   // Config and scan list registers.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         twelve    <= 1'(`ACBC_RST_CONFIG >> `ACBC_F_TWELVE);
         fixed_in  <= 4'(`ACBC_RST_CONFIG >> `ACBC_F_FIX_LO);
         scan_list <= `ACBC_RST_SCANLIST;
      end else if (wr_en) begin
         if (PADDR == `ACBC_OFF_CONFIG) begin
            twelve   <= PWDATA[`ACBC_F_TWELVE];
            fixed_in <= PWDATA[`ACBC_F_FIX_HI:`ACBC_F_FIX_LO];
         end
         if (PADDR == `ACBC_OFF_SCANLIST) begin
            scan_list <= PWDATA[15:0];
         end
      end
   end

   // Read view; unimplemented bits and out-of-scope fields read zero.
   always_comb begin
      ctrl_view = 16'h0000;  // see RULE_09
      ctrl_view[`ACBC_F_SCAN] = scan_en;
      ctrl_view[`ACBC_F_CHAN_HI:`ACBC_F_CHAN_LO] =
         eff_chan(chan_code, twelve);  // see RULE_02
      ctrl_view[`ACBC_F_HALF] = split && half;  // see RULE_04
      ctrl_view[`ACBC_F_RATE_HI:`ACBC_F_RATE_LO] = rate;
      ctrl_view[`ACBC_F_SPLIT] = split;
   end

   // ------------------------------------------------------------
   // Operation grouping
   // ------------------------------------------------------------
   // A rewrite of the control register restarts the current group.
   acbc_op_counter #(
      .W (4)
   ) u_ops (
      .clk     (CLK),
      .reset_n (RESET_N),
      .op_done (op_done),
      .restart (ctrl_wr),
      .limit   (rate),
      .hit     (hit)
   );

   // Buffer half and write position. An operation that ends a group
   // stores its result first, then the position moves on.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         half <= 1'b0;
         addr <= '0;
      end else if (ctrl_wr) begin
         half <= 1'b0;
         addr <= '0;
      end else if (hit && split) begin
         half <= !half;  // see RULE_07
         addr <= half ? '0 : AW'(BUF_DEPTH / 2);  // see RULE_05
      end else if (hit) begin
         addr <= '0;  // see RULE_08
      end else if (op_done) begin
         // Wrap inside the active region so a half never spills over.
         if (split && addr[AW-2:0] == '1)
            addr <= {addr[AW-1], {(AW-1){1'b0}}};
         else
            addr <= addr + 1'b1;
      end
   end

   // Positive input of channel zero for sample A.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         scan_idx <= 4'h0;
      end else if (!scan_en) begin
         scan_idx <= fixed_in;  // see RULE_09
      end else if (op_done) begin
         scan_idx <= next_scan(scan_idx, scan_list);  // see RULE_09
      end
   end

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   // A read clears only the bits it reported; a same-cycle event wins.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         status <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (rd_en && PADDR == `ACBC_OFF_STATUS && PRDATA[i])
               status[i] <= 1'b0;
         end
         if (hit)
            status[`ACBC_ST_RATE] <= 1'b1;  // see RULE_06
         if (hit && split)
            status[`ACBC_ST_HALF] <= 1'b1;
      end
   end
   // Mask written by software; same layout as status.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mask <= `ACBC_RST_MASK;
      end else if (wr_en && PADDR == `ACBC_OFF_MASK) begin
         mask <= PWDATA[1:0];
      end
   end

   // ------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------
   // Read data is chosen in the setup cycle; unmapped gives an error.
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      unique case (PADDR)
         `ACBC_OFF_CTRL:     next_rdata[15:0] = ctrl_view;
         `ACBC_OFF_STATUS:   next_rdata[1:0]  = status;
         `ACBC_OFF_MASK:     next_rdata[1:0]  = mask;
         `ACBC_OFF_CONFIG:   next_rdata[7:0]  = {fixed_in, 3'h0, twelve};
         `ACBC_OFF_SCANLIST: next_rdata[15:0] = scan_list;
         default:            next_err = 1'b1;
      endcase
   end

   // No wait states: PREADY rises for exactly the access cycle.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= setup;
         PRDATA  <= setup && !PWRITE ? next_rdata : 32'h0000_0000;
         PSLVERR <= setup && next_err;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Registered copies, so every pin comes straight from a flip-flop.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CHANNEL_COUNT <= 2'h0;
         SCAN_ENABLE   <= 1'b0;
         CH0_POS_INPUT <= 4'h0;
         DMA_INC       <= 1'b0;
         BUF_HALF      <= 1'b0;
         BUF_ADDR      <= '0;
         IRQ           <= 1'b0;
      end else begin
         CHANNEL_COUNT <= eff_chan(chan_code, twelve);  // see RULE_01
         SCAN_ENABLE   <= scan_en;
         CH0_POS_INPUT <= scan_idx;
         DMA_INC       <= hit;  // see RULE_06
         BUF_HALF      <= half;
         BUF_ADDR      <= addr;
         IRQ           <= |(status & mask);
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [4:0] tally;
   // Operations seen since the last group ended.
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tally <= 5'h00;
      end else if (ctrl_wr || hit) begin
         tally <= 5'h00;
      end else if (op_done) begin
         tally <= tally + 5'h01;
      end
   end

   sequence s_split_hit;
      split && hit && !ctrl_wr;
   endsequence
   sequence s_half_moved;
      ##1 half != $past(half) ##1 BUF_HALF == $past(half, 1);
   endsequence

   a_group_size: assert property (@(posedge CLK) disable iff (!RESET_N)
      hit |-> {1'b0, rate} == tally[3:0] && tally[4] == 1'b0) // see RULE_06
      else $error("group ended after the wrong operation count");

   a_dma_pulse: assert property (@(posedge CLK) disable iff (!RESET_N)
      hit |=> DMA_INC ##1 !DMA_INC || $past(hit))  // see RULE_06
      else $error("DMA increment does not follow group end");

   a_half_toggle: assert property (@(posedge CLK) disable iff (!RESET_N)
      s_split_hit |-> s_half_moved)  // see RULE_07
      else $error("split buffer did not change half");

   a_plain_restart: assert property (@(posedge CLK) disable iff (!RESET_N)
      !split && hit && !ctrl_wr |=> addr == '0 ##1 BUF_ADDR == '0) // see RULE_08
      else $error("plain mode did not restart buffer");

   a_half_view: assert property (@(posedge CLK) disable iff (!RESET_N)
      ctrl_view[`ACBC_F_HALF] == (split && addr[AW-1]))  // see RULE_05
      else $error("half status read back wrong");

   a_twelve_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
      twelve |-> ctrl_view[9:8] == 2'h0 ##1 CHANNEL_COUNT == 2'h0
         || !$past(twelve))  // see RULE_02
      else $error("channel code visible in twelve-bit mode");

   a_chan_follow: assert property (@(posedge CLK) disable iff (!RESET_N)
      !twelve |=> CHANNEL_COUNT == $past(chan_code))  // see RULE_01
      else $error("channel count output wrong");

   a_scan_fixed: assert property (@(posedge CLK) disable iff (!RESET_N)
      !scan_en ##1 !scan_en |-> scan_idx == $past(fixed_in)) // see RULE_09
      else $error("fixed input not held without scanning");

   a_unused_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
      ctrl_view[12:11] == 2'h0 && !ctrl_view[6]
         && ctrl_view[15:13] == 3'h0)  // see RULE_09
      else $error("unimplemented control bits not zero");

   a_irq_level: assert property (@(posedge CLK) disable iff (!RESET_N)
      (|(status & mask)) |=> IRQ)
      else $error("interrupt not raised for pending status");

endmodule : acbc_top

`default_nettype wire

// file: hdl/acbc_map.svh
// Register offsets, field positions and reset values of the converter
// channel and buffer control slice.
// Assumes a 32-bit APB bus with one register per aligned word.
`ifndef ACBC_MAP_SVH
`define ACBC_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define ACBC_OFF_CTRL      8'h00
`define ACBC_OFF_STATUS    8'h04
`define ACBC_OFF_MASK      8'h08
`define ACBC_OFF_CONFIG    8'h0c
`define ACBC_OFF_SCANLIST  8'h10

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define ACBC_F_SCAN        10
`define ACBC_F_CHAN_HI     9
`define ACBC_F_CHAN_LO     8
`define ACBC_F_HALF        7
`define ACBC_F_RATE_HI     5
`define ACBC_F_RATE_LO     2
`define ACBC_F_SPLIT       1

// ------------------------------------------------------------
// Config register fields and status bits
// ------------------------------------------------------------
`define ACBC_F_TWELVE      0
`define ACBC_F_FIX_HI      7
`define ACBC_F_FIX_LO      4
`define ACBC_ST_RATE       0
`define ACBC_ST_HALF       1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ACBC_RST_CTRL      16'h0000
`define ACBC_RST_CONFIG    8'h00
`define ACBC_RST_SCANLIST  16'h0001
`define ACBC_RST_MASK      2'h0

`endif

// file: hdl/acbc_pkg.sv
// Types shared by the channel and buffer control slice.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package acbc_pkg;

   // Channel-count codes as written by software.
   typedef enum logic [1:0] {
      ACBC_CH_ONE  = 2'h0,
      ACBC_CH_TWO  = 2'h1,
      ACBC_CH_FOUR = 2'h2,
      ACBC_CH_FOUR_ALT = 2'h3
   } acbc_chan_t;

   typedef logic [31:0] acbc_word_t;

endpackage : acbc_pkg
`default_nettype wire

// file: hdl/acbc_op_counter.sv
// Counts completed sample/conversion operations and flags every N+1st.
// Assumes op_done is a one-cycle pulse on clk.
`timescale 1ns/100ps
`default_nettype none

module acbc_op_counter #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         op_done,
   input  wire logic         restart,
   input  wire logic [W-1:0] limit,
   output logic              hit
);

   logic [W-1:0] count;

   if (W < 1) begin : g_bad_width
      $error("acbc_op_counter: W must be at least 1");
   end

   // The operation that reaches the limit is the N+1st one.
   assign hit = op_done && (count == limit);  // see RULE_06

   // A restart drops any partial group so a new rate starts clean.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
      end else if (restart || hit) begin
         count <= '0;
      end else if (op_done) begin
         count <= count + 1'b1;
      end
   end

   a_hit_bound: assert property (@(posedge clk) disable iff (!reset_n)
      count <= limit || restart)  // see RULE_06
      else $error("operation count ran past the limit");

endmodule : acbc_op_counter

`default_nettype wire

// file: dv/acbc_top_tb.sv
// Self-checking bench for the converter channel and buffer control slice.
// Assumes the design files under hdl/ compile first; it drives APB and
// the conversion-done pin itself, with no separate far-side model.
`timescale 1ns/100ps
`default_nettype none
`include "acbc_map.svh"

module acbc_top_tb;
   import acbc_pkg::*;

   // ------------------------------------------------------------
   // Signals and instance
   // ------------------------------------------------------------
   logic             clk, reset_n, psel, penable, pwrite, conv_done;
   logic [7:0]       paddr;
   acbc_word_t       pwdata, prdata, rd;
   logic             pready, pslverr, scan_enable, dma_inc, buf_half, irq;
   logic             err;
   logic [1:0]       channel_count;
   logic [3:0]       ch0_pos_input;
   logic [3:0]       buf_addr;
   int               fails, checked, cycles, dma_cnt, d0;

   acbc_top #(.BUF_DEPTH(16)) u_dut (
      .CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .CONV_DONE(conv_done),
      .CHANNEL_COUNT(channel_count), .SCAN_ENABLE(scan_enable),
      .CH0_POS_INPUT(ch0_pos_input), .DMA_INC(dma_inc),
      .BUF_HALF(buf_half), .BUF_ADDR(buf_addr), .IRQ(irq));

   // ------------------------------------------------------------
   // Clock, timeout and pulse monitor
   // ------------------------------------------------------------
   // The clock toggles every 5 ns, half of its 10 ns period.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A hang is cut short well above the few hundred cycles expected.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         tally_and_finish();
      end
   end

   // Pulses are counted at the falling edge, where outputs are settled.
   always @(negedge clk) begin
      if (dma_inc === 1'b1) dma_cnt++;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Compares words; any unknown bit counts as a mismatch.
   task chk_word(input acbc_word_t g, input acbc_word_t e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_word

   // Compares single flags.
   task chk_flag(input logic g, input logic e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_flag

   // One APB transfer. It starts one edge after the last release, so no
   // signal is assigned twice in a time step; pready, read data and the
   // error flag are all taken at the rising edge that samples pready high.
   task apb(input logic w, input logic [7:0] a, input acbc_word_t d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // One completed operation: a pin pulse wide enough for the synchroniser,
   // then enough idle cycles for the pulse and interrupt to land.
   task conv_op();
      @(posedge clk);
      conv_done <= 1'b1;
      repeat (3) @(posedge clk);
      conv_done <= 1'b0;
      repeat (7) @(posedge clk);
   endtask : conv_op

   task tally_and_finish();
      $display("TB: checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   // ------------------------------------------------------------
   // Control register rows: written value, read-back, channel code, scan
   // ------------------------------------------------------------
   typedef struct {
      acbc_word_t wd;
      acbc_word_t rb;
      logic [1:0] cc;
      logic       sc;
   } acbc_row_t;

   acbc_row_t rows [5] = '{
      '{32'h0000_0000, 32'h0000_0000, 2'h0, 1'b0},
      '{32'h0000_0100, 32'h0000_0100, 2'h1, 1'b0},
      '{32'h0000_0200, 32'h0000_0200, 2'h2, 1'b0},
      '{32'h0000_0300, 32'h0000_0300, 2'h3, 1'b0},
      '{32'hffff_ffff, 32'h0000_073e, 2'h3, 1'b1}};

   int rates [3] = '{0, 1, 15};

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, conv_done, paddr, pwdata} = '0;
      {fails, checked, cycles, dma_cnt} = '0;
      reset_n = 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;

      // Field placement, read-only half bit and unused bits reading zero.
      foreach (rows[i]) begin
         apb(1'b1, `ACBC_OFF_CTRL, rows[i].wd);
         apb(1'b0, `ACBC_OFF_CTRL, '0);
         chk_word(rd, rows[i].rb);
         chk_word({30'h0, channel_count}, {30'h0, rows[i].cc});
         chk_flag(scan_enable, rows[i].sc);
      end
      $display("TB: control rows done");

      // Mid-run reset brings the control and scan list registers back to their reset values.
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk_word({30'h0, channel_count}, '0);
      reset_n <= 1'b1;
      apb(1'b0, `ACBC_OFF_CTRL, '0);
      chk_word(rd, 32'h0000_0000);
      apb(1'b0, `ACBC_OFF_SCANLIST, '0);
      chk_word(rd, 32'h0000_0001);
      chk_flag(err, 1'b0);
      apb(1'b0, 8'h20, '0);
      chk_flag(err, 1'b1);
      chk_word(rd, '0);
      $display("TB: reset and unmapped done");

      // Twelve-bit mode hides the stored channel code.
      apb(1'b1, `ACBC_OFF_CONFIG, 32'h51);
      apb(1'b1, `ACBC_OFF_CTRL, 32'h0300);
      apb(1'b0, `ACBC_OFF_CTRL, '0);
      chk_word(rd, 32'h0000_0000);
      chk_word({30'h0, channel_count}, '0);
      chk_word({28'h0, ch0_pos_input}, 32'h5);
      apb(1'b1, `ACBC_OFF_CONFIG, 32'h50);
      apb(1'b0, `ACBC_OFF_CTRL, '0);
      chk_word(rd, 32'h0000_0300);
      $display("TB: twelve-bit mode done");

      // Plain mode: one event per rate+1 ops, storage restarts at zero.
      foreach (rates[k]) begin
         apb(1'b1, `ACBC_OFF_CTRL, 32'(rates[k] << 2));
         d0 = dma_cnt;
         repeat (rates[k]) conv_op();
         chk_word(32'(dma_cnt - d0), 32'h0);
         chk_word({28'h0, buf_addr}, 32'(rates[k]));
         conv_op();
         chk_word(32'(dma_cnt - d0), 32'h1);
         chk_word({28'h0, buf_addr}, 32'h0);
         apb(1'b0, `ACBC_OFF_CTRL, '0);
         chk_flag(rd[7], 1'b0);
      end
      $display("TB: plain mode rates done");

      // Plain-mode events left status set; clear it before unmasking.
      apb(1'b0, `ACBC_OFF_STATUS, '0);
      chk_word(rd, 32'h1);
      // Split mode, two ops a group: halves alternate at each event.
      apb(1'b1, `ACBC_OFF_MASK, 32'h1);
      apb(1'b1, `ACBC_OFF_CTRL, 32'h0006);
      conv_op();
      chk_flag(irq, 1'b0);
      conv_op();
      chk_flag(buf_half, 1'b1);
      chk_word({28'h0, buf_addr}, 32'h8);
      chk_flag(irq, 1'b1);
      apb(1'b0, `ACBC_OFF_CTRL, '0);
      chk_flag(rd[7], 1'b1);
      apb(1'b0, `ACBC_OFF_STATUS, '0);
      chk_word(rd, 32'h3);
      repeat (2) @(posedge clk);
      chk_flag(irq, 1'b0);
      repeat (2) conv_op();
      chk_flag(buf_half, 1'b0);
      chk_word({28'h0, buf_addr}, 32'h0);
      apb(1'b0, `ACBC_OFF_CTRL, '0);
      chk_flag(rd[7], 1'b0);
      apb(1'b1, `ACBC_OFF_MASK, 32'h0);
      apb(1'b0, `ACBC_OFF_STATUS, '0);
      repeat (2) conv_op();
      chk_flag(irq, 1'b0);
      $display("TB: split mode done");

      // Scan steps from fixed input 5 to listed input 1, then to 2.
      apb(1'b1, `ACBC_OFF_SCANLIST, 32'h0006);
      apb(1'b1, `ACBC_OFF_CTRL, 32'h0400);
      conv_op();
      chk_word({28'h0, ch0_pos_input}, 32'h1);
      conv_op();
      chk_word({28'h0, ch0_pos_input}, 32'h2);
      $display("TB: scan done");

      tally_and_finish();
   end

endmodule : acbc_top_tb
`default_nettype wire
